// file: design/timer_event_counter_control.sv
// 16-bit timer/event counter with mode decode, trigger, capture and output pins
`timescale 1ns/100ps
module timer_event_counter_control
    import timer_event_pkg::*;
(
    input  wire logic                     core_clk,
    input  wire logic                     rstn,
    input  wire logic                     timerRunEnable,
    input  wire timer_cfg_type            cfg,
    input  wire logic [COUNTER_WIDTH-1:0] compareValue,
    input  wire logic                     softwareTrigger,
    input  wire logic                     extEventPin,
    input  wire logic [CAPTURE_COUNT-1:0] capturePin,
    output logic [OUTPUT_COUNT-1:0]       timerOutputPin,
    output logic [COUNTER_WIDTH-1:0]      counterValue,
    output logic [COUNTER_WIDTH-1:0]      captureData0,
    output logic [COUNTER_WIDTH-1:0]      captureData1,
    output logic [CAPTURE_COUNT-1:0]      captureStrobe,
    output logic                          triggerArmed
);

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic isTrigMode(input logic [2:0] m);
        isTrigMode = (m == MODE_EXT_TRIG) || (m == MODE_ONE_SHOT);
    endfunction : isTrigMode

    function automatic logic isCapMode(input logic [2:0] m);
        isCapMode = (m == MODE_FREE_RUN) || (m == MODE_PULSE_MEAS);
    endfunction : isCapMode

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic                     evtRise;
    logic [CAPTURE_COUNT-1:0] capRise;
    logic [CAPTURE_COUNT-1:0] capFall;

    edge_sync u_evt (
        .core_clk (core_clk),
        .rstn     (rstn),
        .pinIn    (extEventPin),
        .rise     (evtRise),
        .fall     ()
    );

    edge_sync u_cap0 (
        .core_clk (core_clk),
        .rstn     (rstn),
        .pinIn    (capturePin[0]),
        .rise     (capRise[0]),
        .fall     (capFall[0])
    );

    edge_sync u_cap1 (
        .core_clk (core_clk),
        .rstn     (rstn),
        .pinIn    (capturePin[1]),
        .rise     (capRise[1]),
        .fall     (capFall[1])
    );

    ////////////////////////////////////////////////////////////////////////////
    // count source, trigger and capture decode

    run_state_type            state_q;
    run_state_type            state_d;
    logic                     armed_q;
    logic [COUNTER_WIDTH-1:0] counter_q;
    logic [OUTPUT_COUNT-1:0]  toggle_q;
    logic [OUTPUT_COUNT-1:0]  pin_q;
    logic [COUNTER_WIDTH-1:0] cap0_q;
    logic [COUNTER_WIDTH-1:0] cap1_q;
    logic [CAPTURE_COUNT-1:0] capStrobe_q;
    logic                     countTick;
    logic                     match;
    logic                     trigTaken;
    logic [CAPTURE_COUNT-1:0] capHit;

    always_comb begin
        // event mode always counts pin edges, event enable ignored there
        if (cfg.mode == MODE_EXT_EVENT || cfg.extEventSourceSelect) begin
            countTick = evtRise;
        end else begin
            countTick = 1'b1;
        end
    end

    assign match     = (counter_q == compareValue);
    // trigger outside the two pulse modes is dropped
    assign trigTaken = timerRunEnable && softwareTrigger && isTrigMode(cfg.mode);

    always_comb begin
        for (int i = 0; i < CAPTURE_COUNT; i++) begin
            capHit[i] = isCapMode(cfg.mode) && timerRunEnable
                        && ((cfg.captureEdgeSel[2*i+EDGE_RISE_POS] && capRise[i])
                        ||  (cfg.captureEdgeSel[2*i+EDGE_FALL_POS] && capFall[i]));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // run state

    always_comb begin
        state_d = state_q;
        case (state_q)
            RUN_IDLE: begin
                if (timerRunEnable) begin
                    state_d = isTrigMode(cfg.mode) ? RUN_WAIT_TRIGGER : RUN_COUNTING;
                end
            end
            RUN_WAIT_TRIGGER: begin
                if (trigTaken) begin
                    state_d = RUN_COUNTING;
                end
            end
            RUN_COUNTING: begin
                // one-shot fires once and waits for a fresh trigger
                if (cfg.mode == MODE_ONE_SHOT && countTick && match && !trigTaken) begin
                    state_d = RUN_WAIT_TRIGGER;
                end
            end
            default: begin
                state_d = RUN_IDLE;
            end
        endcase
        if (!timerRunEnable) begin
            state_d = RUN_IDLE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state_q <= RUN_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // armed flag kept in its own flop so the output needs no decode after the state register
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            armed_q <= 1'b0;
        end else begin
            armed_q <= (state_d == RUN_COUNTING);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // counter

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            counter_q <= COUNTER_RESET;
        end else if (!timerRunEnable || state_q != RUN_COUNTING) begin
            counter_q <= COUNTER_RESET;
        end else if (trigTaken) begin
            counter_q <= COUNTER_RESET;
        end else if (cfg.mode == MODE_PULSE_MEAS && capHit != '0) begin
            counter_q <= COUNTER_RESET;
        end else if (countTick) begin
            // free-running and pulse width modes wrap at full scale, other modes clear on match
            if (match && cfg.mode != MODE_FREE_RUN && cfg.mode != MODE_PULSE_MEAS) begin
                counter_q <= COUNTER_RESET;
            end else begin
                counter_q <= counter_q + COUNTER_ONE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // capture

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            cap0_q      <= COUNTER_RESET;
            cap1_q      <= COUNTER_RESET;
            capStrobe_q <= '0;
        end else begin
            capStrobe_q <= capHit;
            if (capHit[0]) begin
                cap0_q <= counter_q;
            end
            if (capHit[1]) begin
                cap1_q <= counter_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output pins

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            toggle_q <= '0;
        end else if (!timerRunEnable || state_q != RUN_COUNTING) begin
            toggle_q <= '0;
        end else if (countTick && match && !isCapMode(cfg.mode)) begin
            toggle_q <= ~toggle_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            pin_q <= PIN_RESET;
        end else begin
            for (int i = 0; i < OUTPUT_COUNT; i++) begin
                // stopped or disabled pin still shows its level bit
                if (timerRunEnable && cfg.outputPinEnable[i]) begin
                    pin_q[i] <= cfg.outputLevelSelect[i] ^ toggle_q[i];
                end else begin
                    pin_q[i] <= cfg.outputLevelSelect[i];
                end
            end
        end
    end

    assign timerOutputPin = pin_q;
    assign counterValue   = counter_q;
    assign captureData0   = cap0_q;
    assign captureData1   = cap1_q;
    assign captureStrobe  = capStrobe_q;
    assign triggerArmed   = armed_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    sequence stoppedTwo;
        !timerRunEnable [*2];
    endsequence

    sequence idleTrigger;
        timerRunEnable && softwareTrigger && !isTrigMode(cfg.mode) && state_q == RUN_COUNTING
        && countTick && !match && cfg.mode != MODE_PULSE_MEAS;
    endsequence

    chk_trig_ignored: assert property (@(posedge core_clk) disable iff (!rstn)
        idleTrigger |=> counter_q == $past(counter_q) + COUNTER_ONE)
        else $error("software trigger acted outside a pulse mode");

    chk_trig_taken: assert property (@(posedge core_clk) disable iff (!rstn)
        (timerRunEnable && state_q == RUN_WAIT_TRIGGER && trigTaken) |=> triggerArmed && counter_q == COUNTER_RESET)
        else $error("software trigger in pulse mode not taken");

    chk_event_source: assert property (@(posedge core_clk) disable iff (!rstn)
        (cfg.mode == MODE_EXT_EVENT && !cfg.extEventSourceSelect) |-> countTick == evtRise)
        else $error("event mode not counting the event pin");

    chk_event_decode: assert property (@(posedge core_clk) disable iff (!rstn)
        (timerRunEnable && state_q == RUN_COUNTING && cfg.mode == MODE_EXT_EVENT && !evtRise
         && $stable(cfg.mode)) |=> $stable(counter_q) || !timerRunEnable)
        else $error("counter moved without an external event");

    chk_idle_level: assert property (@(posedge core_clk) disable iff (!rstn)
        (!timerRunEnable || !cfg.outputPinEnable[0]) |=> timerOutputPin[0] == $past(cfg.outputLevelSelect[0]))
        else $error("stopped pin does not show its level bit");

    chk_no_capture: assert property (@(posedge core_clk) disable iff (!rstn)
        !isCapMode(cfg.mode) |=> captureStrobe == '0 && $stable(captureData0) && $stable(captureData1))
        else $error("capture outside capture modes");

    chk_capture_value: assert property (@(posedge core_clk) disable iff (!rstn)
        capHit[0] |=> captureStrobe[0] && captureData0 == $past(counter_q))
        else $error("capture did not latch the counter");

    chk_pulse_wait: assert property (@(posedge core_clk) disable iff (!rstn)
        (timerRunEnable && $rose(timerRunEnable) && isTrigMode(cfg.mode))
        |=> !triggerArmed && counter_q == COUNTER_RESET)
        else $error("pulse mode started without a trigger");

    chk_stop_clear: assert property (@(posedge core_clk) disable iff (!rstn)
        stoppedTwo |-> counter_q == COUNTER_RESET && !triggerArmed)
        else $error("counter not cleared while stopped");

endmodule : timer_event_counter_control

// file: design/timer_event_pkg.sv
// constants, modes and configuration carrier for the 16-bit timer/event counter control
//
// Operation
// - software trigger acts only in external trigger or one-shot pulse mode
// - external event count mode counts external events whatever the event enable holds
// - each output pin follows its level bit while stopped and disabled
// - capture happens only in free-running and pulse width measurement modes
// - mode value 001 selects external event count mode
// - mode 010 is external trigger pulse, 011 is one-shot pulse
package timer_event_pkg;

    localparam int COUNTER_WIDTH = 16;
    localparam int OUTPUT_COUNT  = 2;
    localparam int CAPTURE_COUNT = 2;

    localparam logic [2:0] MODE_INTERVAL   = 3'h0;
    localparam logic [2:0] MODE_EXT_EVENT  = 3'h1;
    localparam logic [2:0] MODE_EXT_TRIG   = 3'h2;
    localparam logic [2:0] MODE_ONE_SHOT   = 3'h3;
    localparam logic [2:0] MODE_PWM        = 3'h4;
    localparam logic [2:0] MODE_FREE_RUN   = 3'h5;
    localparam logic [2:0] MODE_PULSE_MEAS = 3'h6;

    // per capture input: bit 0 rising edge, bit 1 falling edge
    localparam int EDGE_RISE_POS = 0;
    localparam int EDGE_FALL_POS = 1;

    localparam logic [COUNTER_WIDTH-1:0] COUNTER_RESET = 16'h0000;
    localparam logic [COUNTER_WIDTH-1:0] COUNTER_ONE   = 16'h0001;
    localparam logic [OUTPUT_COUNT-1:0]  PIN_RESET     = 2'h0;

    typedef struct packed {
        logic [2:0]                   mode;
        logic                         extEventSourceSelect;
        logic [OUTPUT_COUNT-1:0]      outputLevelSelect;
        logic [OUTPUT_COUNT-1:0]      outputPinEnable;
        logic [2*CAPTURE_COUNT-1:0]   captureEdgeSel;
    } timer_cfg_type;

    typedef enum logic [1:0] {
        RUN_IDLE,
        RUN_WAIT_TRIGGER,
        RUN_COUNTING
    } run_state_type;

endpackage : timer_event_pkg

// file: design/edge_sync.sv
// pin synchroniser with rising and falling edge detection
`timescale 1ns/100ps
module edge_sync
    import timer_event_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rstn,
    input  wire logic pinIn,
    output logic      rise,
    output logic      fall
);
    logic metaQ_q;
    logic syncQ_q;
    logic lastQ_q;

    // first stage read only by the second
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            metaQ_q <= 1'b0;
            syncQ_q <= 1'b0;
            lastQ_q <= 1'b0;
        end else begin
            metaQ_q <= pinIn;
            syncQ_q <= metaQ_q;
            lastQ_q <= syncQ_q;
        end
    end

    assign rise = syncQ_q & ~lastQ_q;
    assign fall = ~syncQ_q & lastQ_q;

endmodule : edge_sync

// file: tb/pin_partner.sv
// external pin model: event source and capture sources
`timescale 1ns/100ps
module pin_partner (
    input  wire logic  core_clk,
    output logic       extEventPin,
    output logic [1:0] capturePin
);
    initial begin
        extEventPin = 1'b0;
        capturePin  = 2'h0;
    end
    ////////////////////////////////////////////////////////////////////////
    // held several cycles so the two-flop synchroniser cannot miss a pulse
    task automatic eventPulse();
        @(negedge core_clk) extEventPin = 1'b1;
        repeat (3) @(negedge core_clk);
        extEventPin = 1'b0;
        repeat (3) @(negedge core_clk);
    endtask : eventPulse
    // levels change only at the falling edge, like every bench input
    task automatic setCapture(input logic [1:0] v);
        @(negedge core_clk) capturePin = v;
    endtask : setCapture
endmodule : pin_partner

// file: tb/tb.sv
// self-checking bench for the timer/event counter control
`timescale 1ns/100ps
module tb;
    import timer_event_pkg::*;
    logic                     core_clk;
    logic                     rstn;
    logic                     timerRunEnable;
    timer_cfg_type            cfg;
    logic [COUNTER_WIDTH-1:0] compareValue;
    logic                     softwareTrigger;
    logic                     extEventPin;
    logic [CAPTURE_COUNT-1:0] capturePin;
    logic [OUTPUT_COUNT-1:0]  timerOutputPin;
    logic [COUNTER_WIDTH-1:0] counterValue;
    logic [COUNTER_WIDTH-1:0] captureData0;
    logic [COUNTER_WIDTH-1:0] captureData1;
    logic [CAPTURE_COUNT-1:0] captureStrobe;
    logic                     triggerArmed;
    logic [COUNTER_WIDTH-1:0] startVal;
    logic                     seen;
    int                       errorCnt;
    int                       checks;

    timer_event_counter_control i_dut (
        .core_clk(core_clk), .rstn(rstn), .timerRunEnable(timerRunEnable), .cfg(cfg),
        .compareValue(compareValue), .softwareTrigger(softwareTrigger), .extEventPin(extEventPin),
        .capturePin(capturePin), .timerOutputPin(timerOutputPin), .counterValue(counterValue),
        .captureData0(captureData0), .captureData1(captureData1),
        .captureStrobe(captureStrobe), .triggerArmed(triggerArmed)
    );
    pin_partner i_pins (.core_clk(core_clk), .extEventPin(extEventPin), .capturePin(capturePin));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checks, errorCnt);
        if (errorCnt == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    task automatic checkWord(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            errorCnt++;
            $display("CHECK FAILED at %0t: word got %h expected %h", $time, got, exp);
        end
    endtask : checkWord
    task automatic checkFlag(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            errorCnt++;
            $display("CHECK FAILED at %0t: flag got %b expected %b", $time, got, exp);
        end
    endtask : checkFlag
    // stop, change the mode while stopped, then run again
    task automatic runMode(input logic [2:0] m);
        @(negedge core_clk) timerRunEnable = 1'b0;
        @(negedge core_clk) cfg.mode = m;
        @(negedge core_clk) timerRunEnable = 1'b1;
        @(negedge core_clk);
    endtask : runMode
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #(25ns * 5000);
        errorCnt++;
        report_and_stop();
    end
    initial begin
        rstn = 1'b0;
        timerRunEnable = 1'b0;
        cfg = '{mode: MODE_INTERVAL, extEventSourceSelect: 1'b0, outputLevelSelect: 2'h0,
                outputPinEnable: 2'h0, captureEdgeSel: 4'h5};
        compareValue = 16'h0fff;
        softwareTrigger = 1'b0;
        repeat (16) @(negedge core_clk);
        rstn = 1'b1;
        // stopped and disabled pins still follow their level bits
        @(negedge core_clk) cfg.outputLevelSelect = 2'h2;
        repeat (2) @(negedge core_clk);
        checkWord({14'h0, timerOutputPin}, 16'h0002);
        cfg.outputLevelSelect = 2'h1;
        repeat (2) @(negedge core_clk);
        checkWord({14'h0, timerOutputPin}, 16'h0001);
        // counter runs, then clears and stays cleared once stopped
        runMode(MODE_INTERVAL);
        repeat (8) @(negedge core_clk);
        checkFlag(|counterValue, 1'b1);
        timerRunEnable = 1'b0;
        repeat (2) @(negedge core_clk);
        checkWord(counterValue, 16'h0000);
        repeat (5) @(negedge core_clk);
        checkWord(counterValue, 16'h0000);
        // event count mode uses the pin although the source select is clear
        runMode(MODE_EXT_EVENT);
        repeat (3) i_pins.eventPulse();
        repeat (4) @(negedge core_clk);
        checkWord(counterValue, 16'h0003);
        // an enabled pin toggles on match while running, shows its level again once stopped
        @(negedge core_clk) timerRunEnable = 1'b0;
        cfg.outputPinEnable = 2'h1;
        compareValue = 16'h0003;
        runMode(MODE_INTERVAL);
        seen = 1'b0;
        repeat (12) begin
            @(negedge core_clk) seen = seen | ~timerOutputPin[0];
        end
        checkFlag(seen, 1'b1);
        timerRunEnable = 1'b0;
        repeat (2) @(negedge core_clk);
        checkWord({14'h0, timerOutputPin}, 16'h0001);
        cfg.outputPinEnable = 2'h0;
        compareValue = 16'h0fff;
        // trigger acts in the two pulse modes only; elsewhere the count goes on untouched
        for (int m = 0; m < 7; m++) begin
            runMode(3'(m));
            repeat (4) @(negedge core_clk);
            if (m == 2 || m == 3) begin
                checkFlag(triggerArmed, 1'b0);
            end
            startVal = counterValue;
            softwareTrigger = 1'b1;
            @(negedge core_clk) softwareTrigger = 1'b0;
            repeat (2) @(negedge core_clk);
            if (m == 2 || m == 3) begin
                checkFlag(triggerArmed, 1'b1);
                checkFlag(counterValue < 16'h0003, 1'b1);
            end else begin
                checkWord(counterValue, (m == 1) ? 16'h0000 : startVal + 16'h0003);
            end
        end
        // capture strobes only in free-running and pulse width modes
        for (int m = 0; m < 7; m++) begin
            runMode(3'(m));
            seen = 1'b0;
            i_pins.setCapture(2'h3);
            repeat (8) begin
                @(negedge core_clk) seen = seen | captureStrobe[0];
            end
            checkFlag(seen, (m == 5 || m == 6));
            // edge lands two syncs and one edge flop after the pin, counter then at three
            if (m == 5 || m == 6) begin
                checkWord(captureData0, 16'h0003);
                checkWord(captureData1, 16'h0003);
            end else begin
                checkWord(captureData0, 16'h0000);
                checkWord(captureData1, 16'h0000);
            end
            i_pins.setCapture(2'h0);
            repeat (6) @(negedge core_clk);
        end
        report_and_stop();
    end
endmodule : tb
